// ===== hdl/sms_pkg.sv
// Constants and types of the sensor mode sequencer.
// Assumes a 100 MHz core clock.
package sms_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_TICK_NS = 800;
  localparam int RATE_TICK_CYCLES = RATE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] ADDR_DEFAULT = 7'h53;
  localparam logic [6:0] ADDR_STRAPPED = 7'h52;
  localparam logic [4:0] ADDR_TENBIT_PREFIX = 5'h1e;
  localparam int PARAM_DEPTH = 46;
  localparam logic [5:0] PAR_ADDR = 6'h00;
  localparam logic [5:0] PAR_CHANNEL_ENABLE_LIST = 6'h01;
  localparam logic [5:0] PAR_MEASCONFIG0 = 6'h05;
  localparam int PAR_CHAN_STRIDE = 4;
  localparam logic [5:0] PAR_RATE_H = 6'h1a;
  localparam logic [5:0] PAR_RATE_L = 6'h1b;
  localparam logic [5:0] PAR_MEASCOUNT0 = 6'h1c;
  localparam logic [5:0] PAR_THRESH0_H = 6'h25;
  localparam logic [5:0] PAR_THRESH0_L = 6'h26;
  localparam int CTR_SEL_LSB = 6;
  localparam int IRQ_DATA = 0;
  localparam int IRQ_THRESH = 1;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  typedef enum logic [2:0] {SMS_OFF, SMS_INIT, SMS_STANDBY, SMS_FORCED, SMS_AUTO} sms_mode_e;
  typedef enum logic [1:0] {SMS_BUS_IDLE, SMS_BUS_ADDR, SMS_BUS_ACK, SMS_BUS_SKIP} sms_bus_e;
endpackage

// ===== hdl/sms_top.sv
// Mode sequencer, address strap, slave address detect and parameter table.
// Assumes a measurement engine that answers each trigger with a done pulse
// and an I2C register slave outside that takes over after the address ack.
// Function
// - Supply drop reset returns everything to off
// - Software reset re-enters off like power loss
// - Off proceeds directly into initialization
// - Initialization done moves to standby
// - Latch address strap from second LED pin
// - Strap grounded gives 0x52, else 0x53
// - Answer only the selected slave address
// - No measurements while in standby
// - Bus stays active in standby
// - Interrupt holds level until host clears it
// - Register reads never wake the sequencer
// - Force measures enabled channels with selector zero
// - Forced pass completion raises enabled interrupt
// - Start command begins self-timed triggers
// - Period from rate; selector and count nonzero
// - Autonomous results update outputs, raise data interrupt
// - Threshold crossing raises enabled interrupt
// - Status register first, results follow contiguously
// - Programmed address lasts until next reset
// - Only 7-bit addressing is decoded
// - Parameters written one byte per command
// - Parameter table cleared on any reset
`timescale 1ns/1ps
module sms_top
  import sms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_reset,
  input wire logic second_led_pin,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic addr_hit,
  output logic addr_rw,
  output logic bus_active,
  input wire logic cmd_force,
  input wire logic cmd_start,
  input wire logic cmd_pause,
  input wire logic cmd_parameter_write_command,
  input wire logic cmd_param_query,
  input wire logic cmd_new_addr,
  input wire logic [5:0] param_index,
  input wire logic [7:0] param_data,
  output logic [7:0] param_response,
  output logic cmd_error,
  output logic meas_trigger,
  output logic [5:0] meas_channels,
  input wire logic meas_done,
  input wire logic [15:0] meas_result,
  output logic [15:0] result_out,
  input wire logic [1:0] irq_enable,
  input wire logic irq_clear_data,
  input wire logic irq_clear_thresh,
  output logic [1:0] irq_status,
  output logic int_o,
  output logic int_oe_n,
  output logic [2:0] mode,
  output logic [6:0] slave_addr
);
  typedef struct packed {
    sms_mode_e mode;
    logic [7:0] init_cnt;
    logic led_low;
    logic [2:0] led_s;
    logic led_q;
    logic [6:0] addr;
    logic [PARAM_DEPTH-1:0][7:0] params;
    logic [7:0] resp;
    logic err;
    logic busy;
    logic [23:0] rate_cnt;
    logic trig;
    logic [5:0] chans;
    logic [15:0] result;
    logic [1:0] irq;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_q;
    logic sda_q;
    sms_bus_e bus;
    logic [3:0] bitc;
    logic [7:0] shreg;
    logic ack;
    logic hit;
    logic rw;
  } sms_state_s;

  sms_state_s st_r;
  sms_state_s st_nxt;

  function automatic logic [5:0] sms_force_mask(input logic [PARAM_DEPTH-1:0][7:0] p);
    logic [5:0] m;
    logic [7:0] cfg;
    m = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      cfg = p[6'(int'(PAR_MEASCONFIG0) + i * PAR_CHAN_STRIDE)];
      m[i] = p[PAR_CHANNEL_ENABLE_LIST][i] && (cfg[CTR_SEL_LSB +: 2] == 2'h0);
    end
    return m;
  endfunction

  function automatic logic [5:0] sms_auto_mask(input logic [PARAM_DEPTH-1:0][7:0] p);
    logic [5:0] m;
    logic [7:0] cfg;
    logic [1:0] sel;
    m = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      cfg = p[6'(int'(PAR_MEASCONFIG0) + i * PAR_CHAN_STRIDE)];
      sel = cfg[CTR_SEL_LSB +: 2];
      m[i] = p[PAR_CHANNEL_ENABLE_LIST][i] && (sel != 2'h0) && (p[PAR_MEASCOUNT0 + 6'(sel) - 6'h01] != 8'h00);
    end
    return m;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [23:0] period;
  logic [15:0] thresh;
  logic [5:0] fmask;
  logic [5:0] amask;
  logic set_data;
  logic set_thr;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.trig = 1'b0;
    st_nxt.hit = 1'b0;
    set_data = 1'b0;
    set_thr = 1'b0;
    fmask = sms_force_mask(st_r.params);
    amask = sms_auto_mask(st_r.params);
    period = 24'({st_r.params[PAR_RATE_H], st_r.params[PAR_RATE_L]}) * 24'(RATE_TICK_CYCLES);
    thresh = {st_r.params[PAR_THRESH0_H], st_r.params[PAR_THRESH0_L]};

    // Pin synchronisers; a level counts once stages two and three agree
    st_nxt.scl_s = {st_r.scl_s[1:0], scl_i};
    st_nxt.sda_s = {st_r.sda_s[1:0], sda_i};
    if (st_r.scl_s[1] == st_r.scl_s[2])
    begin
      st_nxt.scl_q = st_r.scl_s[2];
    end
    if (st_r.sda_s[1] == st_r.sda_s[2])
    begin
      st_nxt.sda_q = st_r.sda_s[2];
    end
    st_nxt.led_s = {st_r.led_s[1:0], second_led_pin};
    if (st_r.led_s[1] == st_r.led_s[2])
    begin
      st_nxt.led_q = st_r.led_s[2];
    end
    scl_rise = st_nxt.scl_q && !st_r.scl_q;
    scl_fall = !st_nxt.scl_q && st_r.scl_q;
    bus_start = st_r.scl_q && st_nxt.scl_q && st_r.sda_q && !st_nxt.sda_q;
    bus_stop = st_r.scl_q && st_nxt.scl_q && !st_r.sda_q && st_nxt.sda_q;

    // Address phase; the register slave takes over after the ack
    if (bus_stop)
    begin
      st_nxt.bus = SMS_BUS_IDLE;
      st_nxt.ack = 1'b0;
    end
    else if (bus_start)
    begin
      st_nxt.bus = SMS_BUS_ADDR;
      st_nxt.bitc = 4'h0;
      st_nxt.ack = 1'b0;
    end
    else
    begin
      case (st_r.bus)
        SMS_BUS_ADDR:
        begin
          if (scl_rise)
          begin
            st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_q};
            st_nxt.bitc = st_r.bitc + 4'h1;
          end
          else if (scl_fall && st_r.bitc == 4'h8)
          begin
            // Bus answers in standby and autonomous modes alike
            if (st_r.mode != SMS_OFF && st_r.mode != SMS_INIT
                && st_r.shreg[7:3] != ADDR_TENBIT_PREFIX
                && st_r.shreg[7:1] == st_r.addr)
            begin
              st_nxt.bus = SMS_BUS_ACK;
              st_nxt.ack = 1'b1;
              st_nxt.hit = 1'b1;
              st_nxt.rw = st_r.shreg[0];
            end
            else
            begin
              st_nxt.bus = SMS_BUS_SKIP;
            end
          end
        end
        SMS_BUS_ACK:
        begin
          if (scl_fall)
          begin
            st_nxt.ack = 1'b0;
            st_nxt.bus = SMS_BUS_SKIP;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Parameter mailbox, one byte per command
    if (st_r.mode != SMS_OFF && st_r.mode != SMS_INIT)
    begin
      if (cmd_parameter_write_command || cmd_param_query)
      begin
        if (int'(param_index) >= PARAM_DEPTH)
        begin
          st_nxt.err = 1'b1;
        end
        else if (cmd_parameter_write_command)
        begin
          st_nxt.params[param_index] = param_data;
          st_nxt.resp = param_data;
        end
        else
        begin
          st_nxt.resp = st_r.params[param_index];
        end
      end
      else if (cmd_new_addr)
      begin
        st_nxt.addr = st_r.params[PAR_ADDR][6:0];
      end
    end

    // Measurement completion
    if (st_r.busy && meas_done)
    begin
      st_nxt.busy = 1'b0;
      st_nxt.result = meas_result;
      set_data = 1'b1;
      set_thr = meas_result >= thresh;
    end

    case (st_r.mode)
      SMS_OFF:
      begin
        st_nxt.mode = SMS_INIT;
        st_nxt.init_cnt = 8'h00;
      end
      SMS_INIT:
      begin
        st_nxt.init_cnt = st_r.init_cnt + 8'h01;
        if (int'(st_r.init_cnt) == INIT_CYCLES - 1)
        begin
          // Strap sampled at the end of start-up
          st_nxt.led_low = !st_r.led_q;
          st_nxt.addr = st_r.led_q ? ADDR_DEFAULT : ADDR_STRAPPED;
          st_nxt.mode = SMS_STANDBY;
        end
      end
      SMS_STANDBY:
      begin
        // No trigger leaves standby without a command
        if (cmd_force)
        begin
          st_nxt.mode = SMS_FORCED;
          st_nxt.chans = fmask;
          if (fmask != 6'h00)
          begin
            st_nxt.trig = 1'b1;
            st_nxt.busy = 1'b1;
          end
        end
        else if (cmd_start)
        begin
          st_nxt.mode = SMS_AUTO;
          st_nxt.rate_cnt = 24'h000000;
        end
      end
      SMS_FORCED:
      begin
        if (!st_nxt.busy)
        begin
          st_nxt.mode = SMS_STANDBY;
        end
      end
      SMS_AUTO:
      begin
        if (cmd_pause)
        begin
          st_nxt.mode = SMS_STANDBY;
        end
        else if (st_r.rate_cnt + 24'h000001 >= period)
        begin
          st_nxt.rate_cnt = 24'h000000;
          if (!st_r.busy && amask != 6'h00)
          begin
            st_nxt.chans = amask;
            st_nxt.trig = 1'b1;
            st_nxt.busy = 1'b1;
          end
        end
        else
        begin
          st_nxt.rate_cnt = st_r.rate_cnt + 24'h000001;
        end
      end
      default:
      begin
        st_nxt.mode = SMS_OFF;
      end
    endcase

    // Sticky flags; a new event beats a clear in the same cycle
    st_nxt.irq[IRQ_DATA] = set_data || (st_r.irq[IRQ_DATA] && !irq_clear_data);
    st_nxt.irq[IRQ_THRESH] = set_thr || (st_r.irq[IRQ_THRESH] && !irq_clear_thresh);
  end

  always_ff @(posedge clk)
  begin
    if (rst || sw_reset)
    begin
      st_r <= '0;
      st_r.mode <= SMS_OFF;
      st_r.addr <= ADDR_DEFAULT;
      st_r.params <= {PARAM_DEPTH{PARAM_RESET}};
      st_r.bus <= SMS_BUS_IDLE;
      st_r.scl_q <= 1'b1;
      st_r.sda_q <= 1'b1;
      st_r.scl_s <= 3'h7;
      st_r.sda_s <= 3'h7;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = !st_r.ack;
  assign addr_hit = st_r.hit;
  assign addr_rw = st_r.rw;
  assign bus_active = st_r.mode != SMS_OFF && st_r.mode != SMS_INIT;
  assign param_response = st_r.resp;
  assign cmd_error = st_r.err;
  assign meas_trigger = st_r.trig;
  assign meas_channels = st_r.chans;
  assign result_out = st_r.result;
  // Status first, results follow it
  assign irq_status = st_r.irq;
  assign int_o = 1'b0;
  assign int_oe_n = !(|(st_r.irq & irq_enable));
  assign mode = 3'(st_r.mode);
  assign slave_addr = st_r.addr;
endmodule

// ===== testbench/sms_top_props.sv
// Port checker of the mode sequencer.
// Assumes sms_top ports as declared; bound below.
`timescale 1ns/1ps
module sms_top_props
  import sms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_reset,
  input wire logic meas_done,
  input wire logic [1:0] irq_enable,
  input wire logic irq_clear_data,
  input wire logic sda_oe_n,
  input wire logic addr_hit,
  input wire logic bus_active,
  input wire logic meas_trigger,
  input wire logic [1:0] irq_status,
  input wire logic [2:0] mode,
  input wire logic [6:0] slave_addr
);
  localparam int INIT_N = 200;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence init_entry;
    mode == 3'h0 ##1 mode == 3'h1;
  endsequence
  chk_swr_off: assert property (sw_reset |=> mode == 3'h0 && slave_addr == ADDR_DEFAULT) else $error("not off");
  chk_off_init: assert property (mode == 3'h0 && !sw_reset |=> mode == 3'h1) else $error("off stuck");
  chk_init_len: assert property (init_entry |-> ##INIT_N mode == 3'h2) else $error("init length");
  chk_stby_quiet: assert property (mode == 3'h2 && $past(mode) == 3'h2 |-> !meas_trigger) else $error("trig");
  chk_bus_live: assert property (bus_active == (mode >= 3'h2)) else $error("bus state");
  chk_irq_hold: assert property (irq_status[0] && !irq_clear_data && !sw_reset |=> irq_status[0])
    else $error("irq dropped");
  chk_done_irq: assert property (meas_done && irq_enable[0] && mode >= 3'h3 |=> irq_status[0])
    else $error("no irq");
  chk_hit_ack: assert property (addr_hit |-> ##[0:1] !sda_oe_n) else $error("no ack");
  chk_hit_stay: assert property (addr_hit && mode == 3'h2 |=> mode == 3'h2) else $error("woke");
  chk_trig_once: assert property (meas_trigger |=> !meas_trigger) else $error("trig long");
  chk_force_back: assert property (mode == 3'h3 && meas_done |-> ##[1:2] mode == 3'h2) else $error("stuck");
endmodule
bind sms_top sms_top_props sms_top_props_inst (.clk(clk), .rst(rst), .sw_reset(sw_reset), .meas_done(meas_done),
  .irq_enable(irq_enable), .irq_clear_data(irq_clear_data), .sda_oe_n(sda_oe_n), .addr_hit(addr_hit),
  .bus_active(bus_active), .meas_trigger(meas_trigger), .irq_status(irq_status), .mode(mode), .slave_addr(slave_addr));

// ===== testbench/sms_host_model.sv
// Bus master that sends one address byte per frame.
// Assumes a pulled-up data line and a 160 ns bus clock.
`timescale 1ns/1ps
module sms_host_model
(
  output logic scl,
  output logic sda,
  input wire logic dev_sda_oe_n
);
  logic drv;
  assign sda = drv & dev_sda_oe_n;
  initial
  begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // Start, eight bits MSB first, ack slot, stop
  task automatic address(input logic [7:0] b, output logic ack);
    drv = 1'b0;
    #80;
    for (int i = 7; i >= -1; i--)
    begin
      scl = 1'b0;
      #40 drv = (i < 0) ? 1'b1 : b[i];
      #40 scl = 1'b1;
      #40;
      if (i < 0)
        ack = !sda;
      #40;
    end
    scl = 1'b0;
    #40 drv = 1'b0;
    #40 scl = 1'b1;
    #40 drv = 1'b1;
  endtask
endmodule

// ===== testbench/sms_top_test.sv
// Self-checking bench of the mode sequencer.
// Assumes the host bus model and the bound checker.
`timescale 1ns/1ps
module sms_top_test
  import sms_pkg::*;
;
  logic clk, rst, sw_reset, led, meas_done, scl, sda, sda_oe_n, trig, cerr, ack, rw, intn;
  logic [5:0] cmd, pidx, mch;
  logic [7:0] pdat, presp;
  logic [1:0] ien, ist, clr;
  logic [2:0] mode;
  logic [6:0] saddr;
  logic [15:0] res, rout;
  int errors, checks, dly, n, ntrig;
  sms_top sms_top_inst (.clk(clk), .rst(rst), .sw_reset(sw_reset), .second_led_pin(led), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_n(sda_oe_n), .addr_hit(), .addr_rw(rw), .bus_active(), .cmd_force(cmd[0]), .cmd_start(cmd[1]),
    .cmd_pause(cmd[2]), .cmd_parameter_write_command(cmd[3]), .cmd_param_query(cmd[4]), .cmd_new_addr(cmd[5]),
    .param_index(pidx), .param_data(pdat), .param_response(presp), .cmd_error(cerr), .meas_trigger(trig),
    .meas_channels(mch), .meas_done(meas_done), .meas_result(res), .result_out(rout), .irq_enable(ien),
    .irq_clear_data(clr[0]), .irq_clear_thresh(clr[1]), .irq_status(ist), .int_o(), .int_oe_n(intn), .mode(mode),
    .slave_addr(saddr));
  sms_host_model sms_host_model_inst (.scl(scl), .sda(sda), .dev_sda_oe_n(sda_oe_n));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Measurement engine answers each trigger four cycles later
  always @(posedge clk)
  begin
    meas_done <= (dly == 1);
    dly <= trig ? 3 : (dly > 0 ? dly - 1 : 0);
    ntrig <= ntrig + int'(trig === 1'b1);
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic issue(input logic [5:0] c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= 6'h00;
  endtask
  task automatic pset(input logic [5:0] i, input logic [7:0] d, input logic [5:0] c);
    pidx <= i;
    pdat <= d;
    issue(c);
    @(negedge clk);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    @(negedge clk);
    n = 0;
    while (mode !== m && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    chk("mode", 16'(m), 16'(mode));
  endtask
  task automatic host(input logic [7:0] b, input logic e);
    sms_host_model_inst.address(b, ack);
    chk("ack", 16'(e), 16'(ack));
  endtask
  task automatic wait_trig();
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (trig !== 1'b1 && n < 4000);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    sw_reset = 1'b0;
    led = 1'b1;
    cmd = 6'h00;
    pidx = 6'h00;
    pdat = 8'h00;
    res = 16'h1234;
    ien = 2'h3;
    clr = 2'h0;
    meas_done = 1'b0;
    dly = 0;
    ntrig = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_mode(3'h2);
    chk("addr", 16'(ADDR_DEFAULT), 16'(saddr));
    host(8'ha6, 1'b1);
    chk("rw", 16'h0000, 16'(rw));
    host(8'ha4, 1'b0);
    host(8'hf0, 1'b0);
    chk("mode", 16'h0002, 16'(mode));
    pset(PAR_CHANNEL_ENABLE_LIST, 8'h01, 6'h08);
    chk("resp", 16'h0001, 16'(presp));
    pset(PAR_MEASCONFIG0, 8'h00, 6'h08);
    pset(PAR_THRESH0_H, 8'h10, 6'h08);
    ntrig = 0;
    issue(6'h01);
    @(negedge clk);
    chk("chan", 16'h0001, 16'(mch));
    repeat (20) @(negedge clk);
    chk("passes", 16'h0001, 16'(ntrig));
    chk("mode", 16'h0002, 16'(mode));
    chk("irq", 16'h0003, 16'(ist));
    chk("int", 16'h0000, 16'(intn));
    chk("result", 16'h1234, rout);
    @(posedge clk) clr <= 2'h3;
    @(posedge clk) clr <= 2'h0;
    @(negedge clk);
    chk("irq", 16'h0000, 16'(ist));
    chk("int", 16'h0001, 16'(intn));
    pset(6'h2e, 8'h00, 6'h08);
    chk("err", 16'h0001, 16'(cerr));
    pset(PAR_MEASCONFIG0, 8'h40, 6'h08);
    pset(PAR_MEASCOUNT0, 8'h01, 6'h08);
    pset(PAR_RATE_L, 8'h02, 6'h08);
    res = 16'h0abc;
    issue(6'h02);
    wait_trig();
    wait_trig();
    chk("period", 16'd160, 16'(n));
    chk("chan", 16'h0001, 16'(mch));
    repeat (10) @(negedge clk);
    chk("result", 16'h0abc, rout);
    chk("irq", 16'h0001, 16'(ist));
    issue(6'h04);
    wait_mode(3'h2);
    pset(PAR_ADDR, 8'h30, 6'h08);
    issue(6'h20);
    @(negedge clk);
    chk("addr", 16'h0030, 16'(saddr));
    host(8'h60, 1'b1);
    @(posedge clk) led <= 1'b0;
    sw_reset <= 1'b1;
    @(posedge clk) sw_reset <= 1'b0;
    wait_mode(3'h2);
    chk("addr", 16'(ADDR_STRAPPED), 16'(saddr));
    host(8'ha5, 1'b1);
    chk("rw", 16'h0001, 16'(rw));
    host(8'ha6, 1'b0);
    pset(PAR_CHANNEL_ENABLE_LIST, 8'h00, 6'h10);
    chk("param", 16'h0000, 16'(presp));
    test_done();
  end
endmodule
